// ### acs_pkg.sv
// shared constants for the converter sequencer
// assumes a byte-wide register map reached over classic wishbone
package acs_pkg;
    // register byte addresses
    localparam logic [4:0] OFS_CTRL_A = 5'h00;
    localparam logic [4:0] OFS_CTRL_B = 5'h04;
    localparam logic [4:0] OFS_SEL    = 5'h08;
    localparam logic [4:0] OFS_RES_LO = 5'h0C;
    localparam logic [4:0] OFS_RES_HI = 5'h10;
    // control a fields
    localparam int BIT_EN    = 7;
    localparam int BIT_START = 6;
    localparam int BIT_AUTO  = 5;
    localparam int BIT_DONE  = 4;
    // control b fields
    localparam int BIT_HS    = 7;
    // input select fields
    localparam int REF_LSB   = 6;
    // trigger source that means free running
    localparam logic [2:0] SRC_FREE = 3'h0;
    // conversion timing in half converter cycles
    localparam logic [5:0] NORM_SAMPLE  = 6'h03;
    localparam logic [5:0] NORM_TOTAL   = 6'h1A;
    localparam logic [5:0] FIRST_SAMPLE = 6'h1B;
    localparam logic [5:0] FIRST_TOTAL  = 6'h32;
    localparam logic [5:0] AUTO_SAMPLE  = 6'h04;
    localparam logic [5:0] AUTO_TOTAL   = 6'h1B;
    localparam logic [5:0] DIFF_SAMPLE  = 6'h05;
    localparam logic [5:0] DIFF_TOTAL   = 6'h1C;
    localparam logic [5:0] LAST_CYCLE   = 6'h02;
    // cpu clock at or below which the prescaler reports an error
    localparam int MIN_CPU_KHZ = 100;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CONV = 2'b01} acs_state_e;

    // ratio of cpu clock to converter clock; high speed halves it, but never below 2
    function automatic logic [7:0] div_ratio(input logic [2:0] sel, input logic hs);
        logic [7:0] r;
        r = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
        if (hs && r > 8'h02)
            r = r >> 1;
        return r;
    endfunction : div_ratio

    // channel codes with the top bit set select a differential pair
    function automatic logic is_diff(input logic [4:0] ch);
        return ch[4];
    endfunction : is_diff
endpackage : acs_pkg

// ### acs_clk_if.sv
// carrier between sequencer and prescaler
// assumes one cpu clock for both ends
`timescale 1ns/100ps
interface acs_clk_if;
    logic       enable;
    logic       restart;
    logic [2:0] divide;
    logic       high_speed;
    logic       rise;
    logic       fall;
    logic       half_rate;
    modport seq (output enable, output restart, output divide, output high_speed,
                 input rise, input fall, input half_rate);
    modport pre (input enable, input restart, input divide, input high_speed,
                 output rise, output fall, output half_rate);
endinterface : acs_clk_if

// ### acs_prescaler.sv
// converter clock prescaler: rise and fall enable pulses
// assumes enable and restart come from logic on the cpu clock
`timescale 1ns/100ps
module acs_prescaler #(
    parameter int CPU_KHZ = 50000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sequencer side
    acs_clk_if.pre   pc
);
    if (CPU_KHZ <= acs_pkg::MIN_CPU_KHZ)
    begin : g_slow_cpu
        $error("cpu clock too slow for the prescaler");
    end

    logic [7:0] cnt;
    logic       half;
    wire  [7:0] ratio   = acs_pkg::div_ratio(pc.divide, pc.high_speed);
    // a ratio lowered mid-count must not let the counter wrap
    wire        at_rise = (cnt >= ratio - 8'h01);
    wire        at_fall = (cnt == (ratio >> 1) - 8'h01);
    wire        run     = pc.enable && !pc.restart;

    assign pc.rise      = run && at_rise;
    assign pc.fall      = run && at_fall;
    assign pc.half_rate = half;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt  <= 8'h00;
            half <= 1'b0;
        end
        else if (!run)
        begin
            // held in reset while disabled, restarted on a trigger
            cnt  <= 8'h00;
            half <= 1'b0;
        end
        else
        begin
            cnt  <= at_rise ? 8'h00 : cnt + 8'h01;
            half <= at_rise ? !half : half;
        end
    end
endmodule : acs_prescaler

// ### acs_trigger.sv
// trigger source synchroniser and rising edge detector
// assumes trigger inputs are asynchronous pins
`timescale 1ns/100ps
module acs_trigger (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // trigger pins and selection
    input  wire logic [7:0] pins,
    input  wire logic [2:0] source,
    input  wire logic       armed,
    // one cycle pulse, three clocks after the pin edge
    output logic            edge_pulse
);
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       prev;
    wire        level = sync2[source];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1      <= 8'h00;
            sync2      <= 8'h00;
            prev       <= 1'b0;
            edge_pulse <= 1'b0;
        end
        else
        begin
            sync1      <= pins;
            sync2      <= sync1;
            prev       <= level;
            edge_pulse <= armed && level && !prev;
        end
    end
endmodule : acs_trigger

// ### acs_sequencer.sv
// converter sequencer top: wishbone registers, timing, selection lock
// assumes the analog front end delivers the result on RESULT at completion
//
// Operation
// - prescaler runs only while converter enabled
// - divide select chooses cpu to converter ratio
// - high speed bit allows faster converter clock
// - software start begins at next converter rise
// - normal conversion lasts 13 converter cycles
// - first conversion after enable lasts 25 cycles
// - sample at 1.5, or 13.5 when first
// - completion writes result, sets done, clears start
// - restarting start begins at next converter rise
// - trigger resets prescaler, samples at 2, 13.5
// - trigger path adds three cpu clock latency
// - free running restarts at once, start stays
// - differential aligned to half rate clock phase
// - user differential: 13 or 14 by phase
// - free running differential restarts take 14 cycles
// - selection staged, copied idle, frozen converting
// - copying resumes in last converter cycle
// - ignore triggers while converting, no level restart
// - start reads one while converting
// - low byte read locks result until high read
`timescale 1ns/100ps
module acs_sequencer #(
    parameter int CPU_KHZ = 50000
) (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [4:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // trigger pins
    input  wire logic [7:0]  TRIGGER_IN,
    // analog front end
    input  wire logic [9:0]  RESULT,
    output logic             SAMPLE_HOLD,
    output logic             CONVERTING,
    output logic             ANALOG_ON,
    output logic             HIGH_SPEED,
    output logic [4:0]       CHANNEL,
    output logic [1:0]       REFERENCE
);
    // reset release
    logic rst_m;
    logic rst_n;
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // software state
    logic       enable;
    logic       auto_trig;
    logic [2:0] divide;
    logic       high_speed;
    logic [2:0] src;
    logic       start_bit;
    logic       done_flag;
    logic [4:0] stage_ch;
    logic [1:0] stage_ref;
    logic [9:0] result;
    logic       locked;

    // conversion state
    acs_pkg::acs_state_e state;
    acs_pkg::acs_state_e next_state;
    logic [5:0] half_cnt;
    logic [5:0] sample_at;
    logic [5:0] total_at;
    logic       first_pend;
    logic       ack;
    logic [31:0] rdata;

    acs_clk_if clk_bus ();

    // bus decode
    wire req     = WB_CYC_I && WB_STB_I && !ack;
    wire wr      = req && WB_WE_I && WB_SEL_I[0];
    wire rd      = req && !WB_WE_I;
    wire [7:0] wd = WB_DAT_I[7:0];
    wire wr_a    = wr && (WB_ADR_I == acs_pkg::OFS_CTRL_A);
    wire wr_b    = wr && (WB_ADR_I == acs_pkg::OFS_CTRL_B);
    wire wr_sel  = wr && (WB_ADR_I == acs_pkg::OFS_SEL);
    wire rd_lo   = rd && (WB_ADR_I == acs_pkg::OFS_RES_LO);
    wire rd_hi   = rd && (WB_ADR_I == acs_pkg::OFS_RES_HI);

    // sequencing decode
    wire busy       = (state == acs_pkg::ST_CONV);
    wire tick       = clk_bus.rise || clk_bus.fall;
    wire free_run   = auto_trig && (src == acs_pkg::SRC_FREE);
    wire diff       = acs_pkg::is_diff(CHANNEL);
    wire trig_edge;
    wire auto_go    = enable && auto_trig && !free_run && !busy && trig_edge;
    wire user_go    = enable && start_bit && !busy && clk_bus.rise;
    wire [5:0] cnt_n = half_cnt + 6'h01;
    wire complete   = busy && tick && (cnt_n == total_at);
    wire restart    = complete && free_run;
    wire go         = user_go || auto_go || restart;
    wire last_cycle = busy && (half_cnt + acs_pkg::LAST_CYCLE >= total_at);
    wire copy_sel   = !busy || last_cycle;
    wire en_next    = wr_a ? wd[acs_pkg::BIT_EN] : enable;

    assign clk_bus.enable     = enable;
    assign clk_bus.restart    = auto_go;
    assign clk_bus.divide     = divide;
    assign clk_bus.high_speed = high_speed;

    acs_prescaler #(
        .CPU_KHZ (CPU_KHZ)
    ) u_pre (
        .clk   (CLOCK),
        .rst_n (rst_n),
        .pc    (clk_bus)
    );

    acs_trigger u_trig (
        .clk        (CLOCK),
        .rst_n      (rst_n),
        .pins       (TRIGGER_IN),
        .source     (src),
        .armed      (enable && auto_trig),
        .edge_pulse (trig_edge)
    );

    // sample and total points chosen when a conversion begins
    logic [5:0] go_sample;
    logic [5:0] go_total;
    always_comb
    begin
        go_sample = acs_pkg::NORM_SAMPLE;
        go_total  = acs_pkg::NORM_TOTAL;
        if (first_pend)
        begin
            go_sample = acs_pkg::FIRST_SAMPLE;
            go_total  = acs_pkg::FIRST_TOTAL;
        end
        else if (auto_go)
        begin
            go_sample = acs_pkg::AUTO_SAMPLE;
            go_total  = acs_pkg::AUTO_TOTAL;
        end
        else if (diff && (restart || clk_bus.half_rate))
        begin
            // restarts land with the half rate clock high
            go_sample = acs_pkg::DIFF_SAMPLE;
            go_total  = acs_pkg::DIFF_TOTAL;
        end
    end

    always_comb
    begin
        next_state = state;
        case (state)
            acs_pkg::ST_IDLE:
                if (go)
                    next_state = acs_pkg::ST_CONV;
            acs_pkg::ST_CONV:
                if (complete && !restart)
                    next_state = acs_pkg::ST_IDLE;
            default:
                next_state = acs_pkg::ST_IDLE;
        endcase
        if (!enable)
            next_state = acs_pkg::ST_IDLE;
    end

    // conversion counter
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state       <= acs_pkg::ST_IDLE;
            half_cnt    <= 6'h00;
            sample_at   <= acs_pkg::NORM_SAMPLE;
            total_at    <= acs_pkg::NORM_TOTAL;
            first_pend  <= 1'b1;
            SAMPLE_HOLD <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            SAMPLE_HOLD <= busy && tick && (cnt_n == sample_at) && enable;
            if (!enable)
                first_pend <= 1'b1;
            else if (go)
            begin
                half_cnt   <= 6'h00;
                sample_at  <= go_sample;
                total_at   <= go_total;
                first_pend <= 1'b0;
            end
            else if (busy && tick)
                half_cnt <= cnt_n;
        end
    end

    // software bits
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable     <= 1'b0;
            auto_trig  <= 1'b0;
            divide     <= 3'h0;
            high_speed <= 1'b0;
            src        <= 3'h0;
            start_bit  <= 1'b0;
            done_flag  <= 1'b0;
            stage_ch   <= 5'h00;
            stage_ref  <= 2'h0;
        end
        else
        begin
            if (wr_a)
            begin
                enable    <= wd[acs_pkg::BIT_EN];
                auto_trig <= wd[acs_pkg::BIT_AUTO];
                divide    <= wd[2:0];
            end
            if (wr_b)
            begin
                high_speed <= wd[acs_pkg::BIT_HS];
                src        <= wd[2:0];
            end
            if (wr_sel)
            begin
                stage_ch  <= wd[4:0];
                stage_ref <= wd[acs_pkg::REF_LSB +: 2];
            end
            if (!en_next)
                start_bit <= 1'b0;
            else if (wr_a && wd[acs_pkg::BIT_START])
                start_bit <= 1'b1;
            else if (complete && !free_run)
                start_bit <= 1'b0;
            else if (user_go)
                start_bit <= 1'b1;
            // a completion in the clearing cycle keeps the flag set
            if (complete)
                done_flag <= 1'b1;
            else if (wr_a && wd[acs_pkg::BIT_DONE])
                done_flag <= 1'b0;
        end
    end

    // active selection and result
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            CHANNEL   <= 5'h00;
            REFERENCE <= 2'h0;
            result    <= 10'h000;
            locked    <= 1'b0;
        end
        else
        begin
            if (copy_sel && enable)
            begin
                CHANNEL   <= stage_ch;
                REFERENCE <= stage_ref;
            end
            if (complete && !locked)
                result <= RESULT;
            if (rd_lo)
                locked <= 1'b1;
            else if (rd_hi)
                locked <= 1'b0;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (WB_ADR_I)
            acs_pkg::OFS_CTRL_A:
                rdata[7:0] = {enable, start_bit || busy, auto_trig,
                              done_flag, 1'b0, divide};
            acs_pkg::OFS_CTRL_B:
                rdata[7:0] = {high_speed, 4'h0, src};
            acs_pkg::OFS_SEL:
                rdata[7:0] = {stage_ref, 1'b0, stage_ch};
            acs_pkg::OFS_RES_LO:
                rdata[7:0] = result[7:0];
            acs_pkg::OFS_RES_HI:
                rdata[7:0] = {6'h00, result[9:8]};
            default:
                rdata = 32'h0000_0000;
        endcase
    end

    // one wait state answer, every address acknowledged
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack      <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ack      <= req;
            WB_DAT_O <= rd ? rdata : 32'h0000_0000;
        end
    end

    assign WB_ACK_O   = ack;
    assign CONVERTING = busy;
    assign ANALOG_ON  = enable;
    assign HIGH_SPEED = high_speed;
endmodule : acs_sequencer

// ### acs_sequencer_properties.sv
// timing and bus properties of the converter sequencer
// assumes a single cpu clock and the top module ports only
`timescale 1ns/100ps
module acs_sequencer_props #(
    parameter int CPU_KHZ = 50000
) (
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RST_N,
    // wishbone
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [4:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // converter side
    input wire logic [7:0]  TRIGGER_IN,
    input wire logic [9:0]  RESULT,
    input wire logic        SAMPLE_HOLD,
    input wire logic        CONVERTING,
    input wire logic        ANALOG_ON,
    input wire logic        HIGH_SPEED,
    input wire logic [4:0]  CHANNEL,
    input wire logic [1:0]  REFERENCE
);
    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_start;
        $rose(CONVERTING);
    endsequence

    ack_wait_a: assert property (s_take |=> WB_ACK_O)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    off_still_a: assert property (!ANALOG_ON ##1 !ANALOG_ON |-> !CONVERTING)
        else $error("converting while disabled");
    // enable may only come from a write that carries the enable bit
    on_write_a: assert property ($rose(ANALOG_ON) |-> WB_ACK_O && WB_WE_I && WB_SEL_I[0]
        && WB_ADR_I == acs_pkg::OFS_CTRL_A && WB_DAT_I[7])
        else $error("enable rose without write");
    hs_write_a: assert property ($changed(HIGH_SPEED) |-> WB_ACK_O && WB_WE_I
        && WB_ADR_I == acs_pkg::OFS_CTRL_B)
        else $error("high speed changed without write");
    start_on_a: assert property (s_start |-> ANALOG_ON)
        else $error("start while disabled");
    samp_inside_a: assert property (SAMPLE_HOLD |-> CONVERTING && !$past(SAMPLE_HOLD))
        else $error("strobe outside conversion");
    sel_lock_a: assert property (s_start |=> $stable({REFERENCE, CHANNEL}) until_with SAMPLE_HOLD)
        else $error("selection moved before sampling");
    samp_due_a: assert property (s_start |-> ##[1:1000] (SAMPLE_HOLD || !CONVERTING))
        else $error("no sample strobe");
endmodule : acs_sequencer_props

bind acs_sequencer acs_sequencer_props #(.CPU_KHZ(CPU_KHZ)) chk_u (
    .CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TRIGGER_IN(TRIGGER_IN), .RESULT(RESULT),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONVERTING(CONVERTING), .ANALOG_ON(ANALOG_ON),
    .HIGH_SPEED(HIGH_SPEED), .CHANNEL(CHANNEL), .REFERENCE(REFERENCE));

// ### acs_front_model.sv
// analog front end model: holds a new code at every sample strobe
// assumes the sequencer reads the code at completion on the same clock
`timescale 1ns/100ps
module acs_front_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // converter side
    input  wire logic sample_hold,
    output logic [9:0] result
);
    // a distinct code per sample shows which conversion reached the result bytes
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            result <= 10'h100;
        else if (sample_hold)
            result <= result + 10'h0C1;
endmodule : acs_front_model

// ### acs_testbench.sv
// self-checking bench for the converter sequencer
// assumes a 50 MHz cpu clock; converter clock far above its analog range to keep runs short
`timescale 1ns/100ps
module testbench;
    logic        CLOCK = 1'b0;
    logic        RST_N = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] dat = 32'h0;
    logic [7:0]  trg = 8'h00;
    logic [31:0] dat_o, q;
    logic        ack, s_h, conv, on, hs;
    logic [9:0]  res;
    logic [4:0]  chan;
    logic [1:0]  refs;
    int n_mismatch = 0, checks = 0, cnt = 0, len = 0, smp = 0;
    int gcnt = 0, gap = 0, ndone = 0, nsmp = 0, cyc_n = 0;

    always #10 CLOCK = ~CLOCK;

    acs_sequencer #(.CPU_KHZ(50000)) dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TRIGGER_IN(trg), .RESULT(res), .SAMPLE_HOLD(s_h),
        .CONVERTING(conv), .ANALOG_ON(on), .HIGH_SPEED(hs), .CHANNEL(chan), .REFERENCE(refs));
    acs_front_model fe_u (.clk(CLOCK), .rst_n(RST_N), .sample_hold(s_h), .result(res));

    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // conversion length, sample offset and strobe spacing in cpu clocks
    always @(posedge CLOCK)
    begin
        cyc_n++;
        if (s_h === 1'b1)
        begin
            smp = cnt;
            gap = gcnt;
            gcnt = 1;
            nsmp++;
        end
        else
            gcnt++;
        if (conv === 1'b1)
            cnt++;
        else if (cnt != 0)
        begin
            len = cnt;
            cnt = 0;
            ndone++;
        end
        if (cyc_n == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [31:0] r);
        int k;
        k = 0;
        @(posedge CLOCK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        dat <= {24'h0, d};
        do
        begin
            @(posedge CLOCK);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        r = dat_o;
        if (k >= 50)
            n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d, q);
    endtask : wr

    task rdc(input logic [4:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h00, q);
        cmp(q, e);
    endtask : rdc

    task clk(input int n);
        repeat (n) @(posedge CLOCK);
    endtask : clk

    task automatic wd;
        int k, n0;
        k = 0;
        n0 = ndone;
        while (ndone == n0 && k < 3000)
        begin
            @(posedge CLOCK);
            k++;
        end
        if (k >= 3000)
            n_mismatch++;
    endtask : wd

    // code held by the front end after n strobes
    function automatic logic [9:0] rv(input int n);
        return 10'(256 + n * 193);
    endfunction : rv

    task automatic rres;
        logic [9:0] v;
        v = rv(nsmp);
        rdc(acs_pkg::OFS_RES_LO, {24'h0, v[7:0]});
        rdc(acs_pkg::OFS_RES_HI, {30'h0, v[9:8]});
    endtask : rres

    task t_first;
        wr(acs_pkg::OFS_SEL, 8'h45);
        wr(acs_pkg::OFS_CTRL_A, 8'hC2);
        rdc(acs_pkg::OFS_CTRL_A, 32'hC2);
        rdc(5'h14, 32'h0);
        cmp({25'h0, refs, chan}, 32'h25);
        wd();
        cmp(len, 100);
        cmp(smp, 54);
        rdc(acs_pkg::OFS_CTRL_A, 32'h92);
        rres();
    endtask : t_first

    task t_norm;
        wr(acs_pkg::OFS_CTRL_A, 8'hD2);
        clk(4);
        wr(acs_pkg::OFS_SEL, 8'h47);
        cmp(chan, 32'h5);
        wd();
        cmp(len, 52);
        cmp(smp, 6);
        cmp(chan, 32'h7);
        rres();
    endtask : t_norm

    task t_hs;
        wr(acs_pkg::OFS_CTRL_B, 8'h80);
        cmp(hs, 32'h1);
        wr(acs_pkg::OFS_CTRL_A, 8'hD2);
        wd();
        cmp(len, 26);
        cmp(smp, 3);
        wr(acs_pkg::OFS_CTRL_B, 8'h00);
    endtask : t_hs

    task automatic t_lock;
        logic [9:0] v;
        v = rv(nsmp);
        rdc(acs_pkg::OFS_RES_LO, {24'h0, v[7:0]});
        wr(acs_pkg::OFS_CTRL_A, 8'hD2);
        wd();
        rdc(acs_pkg::OFS_CTRL_A, 32'h92);
        rdc(acs_pkg::OFS_RES_HI, {30'h0, v[9:8]});
        rdc(acs_pkg::OFS_RES_LO, {24'h0, v[7:0]});
        rdc(acs_pkg::OFS_RES_HI, {30'h0, v[9:8]});
    endtask : t_lock

    task t_abort;
        wr(acs_pkg::OFS_CTRL_A, 8'hD2);
        clk(20);
        wr(acs_pkg::OFS_CTRL_A, 8'h02);
        clk(1);
        cmp(conv, 32'h0);
        rdc(acs_pkg::OFS_CTRL_A, 32'h02);
        wr(acs_pkg::OFS_CTRL_A, 8'hC2);
        wd();
        cmp(len, 100);
        rres();
    endtask : t_abort

    task automatic t_auto;
        int n0;
        wr(acs_pkg::OFS_CTRL_B, 8'h01);
        wr(acs_pkg::OFS_CTRL_A, 8'hB2);
        clk(10);
        n0 = ndone;
        trg <= 8'hFF;
        clk(30);
        trg <= 8'h00;
        clk(2);
        trg <= 8'hFF;
        wd();
        cmp(len, 54);
        cmp(smp, 8);
        clk(80);
        cmp(ndone, n0 + 1);
        trg <= 8'h00;
        rres();
        // differential auto conversion: toggle enable so it is extended like a first conversion
        wr(acs_pkg::OFS_CTRL_A, 8'h22);
        wr(acs_pkg::OFS_SEL, 8'h52);
        wr(acs_pkg::OFS_CTRL_A, 8'hB2);
        trg <= 8'hFF;
        wd();
        cmp(len, 100);
        cmp(smp, 54);
        trg <= 8'h00;
    endtask : t_auto

    task automatic t_free;
        int k, n;
        k = 0;
        wr(acs_pkg::OFS_CTRL_A, 8'h02);
        wr(acs_pkg::OFS_CTRL_B, 8'h00);
        // settling results are never compared
        wr(acs_pkg::OFS_SEL, 8'h12);
        wr(acs_pkg::OFS_CTRL_A, 8'hF2);
        n = nsmp;
        while (nsmp < n + 3 && k < 1000)
        begin
            @(posedge CLOCK);
            k++;
        end
        cmp(gap, 56);
        wb(1'b0, acs_pkg::OFS_CTRL_A, 8'h00, q);
        cmp(q & 32'h40, 32'h40);
        wr(acs_pkg::OFS_CTRL_A, 8'h02);
    endtask : t_free

    initial
    begin
        clk(5);
        RST_N <= 1'b1;
        clk(3);
        t_first();
        t_norm();
        t_hs();
        t_lock();
        t_abort();
        t_auto();
        t_free();
        close_out();
    end
endmodule : testbench
